/* File: core/mcc_fmul.sv */
// Single-precision multiply, truncating, denormals flushed to zero.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module mcc_fmul (
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  output logic [31:0] y
);
  logic [47:0] mp;
  logic [9:0] ex;
  logic [22:0] fr;
  assign mp = {1'b1, a[22:0]} * {1'b1, b[22:0]};
  always_comb begin
    ex = 10'(a[30:23]) + 10'(b[30:23]) - 10'd127 + 10'(mp[47]);
    fr = mp[47] ? mp[46:24] : mp[45:23];
    if (a[30:23] == 8'h0 || b[30:23] == 8'h0 || ex[9] || ex == 10'h0) begin
      y = 32'h0;
    end else if (ex >= 10'h0FF) begin
      y = {a[31] ^ b[31], 8'hFF, 23'h0};
    end else begin
      y = {a[31] ^ b[31], ex[7:0], fr};
    end
  end
endmodule // mcc_fmul
`default_nettype wire

/* File: core/mcc_pkg.sv */
// Package for the measurement calibration correction block.
// Assumes a 20 MHz clock and a 32-bit APB register bus.
package mcc_pkg;
  // ==========================================================
  // Sizes
  localparam int NCH = 14;
  localparam int NCELL = 10;
  localparam int NTEMP = 10;
  localparam int CAL_BITS = 8;
  localparam logic [3:0] CH_ADC = 4'hD;
  // ==========================================================
  // Nominal gains follow from the reference and full scale.
  localparam int VREF_MV = 1212;
  localparam int CELL_FS_X5 = 5;
  localparam logic [15:0] CELL_GAIN_NOM = 16'(2 * CELL_FS_X5 * VREF_MV);
  localparam logic [15:0] ADC_GAIN_NOM = 16'((2 * CELL_FS_X5 * VREF_MV) / 3);
  localparam logic [15:0] DIV_GAIN_NOM = CELL_GAIN_NOM;
  // Single-precision value of the charge integration factor.
  localparam logic [31:0] CAP_K = 32'h4891A2B4;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 50;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // Register map: page in paddr[11:6], word in paddr[5:2].
  localparam logic [5:0] PG_SCALAR = 6'h00;
  localparam logic [5:0] PG_GAIN = 6'h01;
  localparam logic [5:0] PG_VOLT = 6'h02;
  localparam logic [5:0] PG_TOFS = 6'h03;
  localparam logic [5:0] PG_TEMP = 6'h04;
  localparam logic [5:0] A_CTRL = 6'h00;
  localparam logic [5:0] A_CMD = 6'h04;
  localparam logic [5:0] A_CALRES = 6'h08;
  localparam logic [5:0] A_OV_OVR = 6'h0C;
  localparam logic [5:0] A_UV_OVR = 6'h10;
  localparam logic [5:0] A_VCELL_OFS = 6'h14;
  localparam logic [5:0] A_VDIV_OFS = 6'h18;
  localparam logic [5:0] A_CUR_GAIN = 6'h1C;
  localparam logic [5:0] A_CAP_GAIN = 6'h20;
  localparam logic [5:0] A_CC_OFS = 6'h24;
  localparam logic [5:0] A_CC_SAMP = 6'h28;
  localparam logic [5:0] A_CUR = 6'h2C;
  localparam logic [5:0] A_RAW_CC = 6'h30;
  localparam logic [7:0] CMD_OV = 8'h01;
  localparam logic [7:0] CMD_UV = 8'h02;
  // ==========================================================
  // Types
  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic [31:0] counts;
  } mcc_meas_t;
  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic signed [15:0] value;
  } mcc_temp_t;
  typedef struct packed {
    logic valid;
    logic [23:0] raw;
  } mcc_cc_t;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_TRY = 2'b01,
    CAL_JUDGE = 2'b11,
    CAL_DONE = 2'b10
  } mcc_cal_st_t;
endpackage

/* File: core/mcc_top.sv */
// Calibration correction of voltage, current and temperature results.
// Assumes measurement strobes synchronous to mclk and an APB master.
// What this block does
// - Raw counts minus factory trim, times gain, minus user offset.
// - Unwritten gain falls back to factory trim or nominal default.
// - A written gain replaces factory trim and default.
// - Ten cell gains, gain n for input n minus input n-1.
// - Cell mV is gain times counts over 65536 minus cell offset.
// - Stack, pack, load use own gains and shared divider offset.
// - General ADC input is gain times counts over 65536, no offset.
// - Nominal gains are 12120 for cells and 4040 for ADC input.
// - Full scale is five or 1.667 times the 1.212 V reference.
// - Full access, not update mode: unwritten gain reads factory trim or nominal default.
// - Update mode: gain reads zero unless written, else written value.
// - After update mode, in full access state, gains read back the values in use.
// - Overvoltage calibration searches coefficient, returns and stores it.
// - Nonzero overvoltage override replaces factory threshold trim.
// - Undervoltage calibration searches, returns and stores its coefficient.
// - Current is counts minus offset per samples, times float gain.
// - Charge gain equals current gain times 298261.6178.
// - Current and charge gains are IEEE-754 single precision.
// - Per-sensor temperature offset in 0.1 K added before reporting.
// - Raw current word is 24 bits sign-extended to 32.
`timescale 1ns/1ps
`default_nettype none
module mcc_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic full_access_state,
  input wire mcc_pkg::mcc_meas_t meas,
  input wire logic [31:0] fac_offset_trim,
  input wire logic [mcc_pkg::NCH-1:0][15:0] fac_gain,
  input wire mcc_pkg::mcc_temp_t temp,
  input wire mcc_pkg::mcc_cc_t cc,
  input wire logic [mcc_pkg::CAL_BITS-1:0] fac_ov_trim,
  input wire logic [mcc_pkg::CAL_BITS-1:0] fac_uv_trim,
  input wire logic comp_trip,
  output logic [mcc_pkg::CAL_BITS-1:0] cal_code,
  output logic cal_uv_sel,
  output logic [mcc_pkg::CAL_BITS-1:0] cell_overvoltage_threshold,
  output logic [mcc_pkg::CAL_BITS-1:0] cell_undervoltage_threshold
);
  import mcc_pkg::*;

  // ==========================================================
  // Storage
  logic cfg_update;
  logic [15:0] gain [NCH];
  logic [NCH-1:0] gain_wr;
  logic [15:0] eff_gain [NCH];
  logic [15:0] rd_gain [NCH];
  logic signed [31:0] vcell_ofs;
  logic signed [31:0] vdiv_ofs;
  logic signed [31:0] cc_ofs;
  logic [7:0] cc_samp;
  logic [31:0] cur_gain;
  logic [31:0] cap_gain;
  logic [31:0] cap_next;
  logic [CAL_BITS-1:0] ov_ovr;
  logic [CAL_BITS-1:0] uv_ovr;
  logic [CAL_BITS-1:0] cal_res;
  logic signed [31:0] volt [NCH];
  logic signed [15:0] tofs [NTEMP];
  logic signed [15:0] temp_res [NTEMP];
  logic signed [31:0] cur;
  logic signed [31:0] raw_cc;

  // ==========================================================
  // APB decode
  logic acc;
  logic wr_en;
  logic [5:0] pg;
  logic [3:0] ix;
  logic [31:0] rd_data;
  logic rd_err;
  logic scal_wr;
  assign acc = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite;
  assign pg = paddr[11:6];
  assign ix = paddr[5:2];
  assign scal_wr = wr_en && pg == PG_SCALAR;

  // ==========================================================
  // Gains, one per channel
  for (genvar g = 0; g < NCH; g++) begin : g_gain
    logic [15:0] dflt;
    assign dflt = (g == CH_ADC) ? ADC_GAIN_NOM : ((g >= NCELL) ? DIV_GAIN_NOM : CELL_GAIN_NOM);
    assign eff_gain[g] = gain_wr[g] ? gain[g] : ((fac_gain[g] != 16'h0) ? fac_gain[g] : dflt);
    assign rd_gain[g] = cfg_update ? (gain_wr[g] ? gain[g] : 16'h0)
                      : (gain_wr[g] ? gain[g] : (full_access_state ? eff_gain[g] : 16'h0));
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        gain[g] <= 16'h0;
        gain_wr[g] <= 1'b0;
      end else if (wr_en && pg == PG_GAIN && ix == 4'(g)) begin
        gain[g] <= pwdata[15:0];
        gain_wr[g] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Calibration search
  mcc_cal_st_t cal_st;
  logic cal_go;
  logic [2:0] bitn;
  logic [5:0] settle;
  assign cal_go = scal_wr && paddr[5:0] == A_CMD && cfg_update && cal_st == CAL_IDLE
                  && (pwdata[7:0] == CMD_OV || pwdata[7:0] == CMD_UV);
  // A trip means the applied voltage is at or above the trial threshold,
  // so the bit stays and the search moves on to a higher code.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cal_st <= CAL_IDLE;
      cal_code <= '0;
      cal_uv_sel <= 1'b0;
      bitn <= 3'h0;
      settle <= 6'h0;
    end else begin
      case (cal_st)
        CAL_IDLE: begin
          if (cal_go) begin
            cal_uv_sel <= pwdata[7:0] == CMD_UV;
            cal_code <= CAL_BITS'(1) << (CAL_BITS - 1);
            bitn <= 3'(CAL_BITS - 1);
            settle <= 6'(SETTLE_CYC);
            cal_st <= CAL_TRY;
          end
        end
        CAL_TRY: begin
          settle <= settle - 6'h1;
          if (settle == 6'h1) begin
            cal_st <= CAL_JUDGE;
          end
        end
        CAL_JUDGE: begin
          cal_code <= (comp_trip ? cal_code : cal_code & ~(CAL_BITS'(1) << bitn))
                    | ((bitn != 3'h0) ? CAL_BITS'(1) << (bitn - 3'h1) : '0);
          bitn <= bitn - 3'h1;
          settle <= 6'(SETTLE_CYC);
          cal_st <= (bitn == 3'h0) ? CAL_DONE : CAL_TRY;
        end
        CAL_DONE: begin
          cal_st <= CAL_IDLE;
        end
        default: begin
          cal_st <= CAL_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Scalar registers; a finished search outranks a bus write.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cfg_update <= 1'b0;
      vcell_ofs <= 32'h0;
      vdiv_ofs <= 32'h0;
      cc_ofs <= 32'h0;
      cc_samp <= 8'h1;
      cur_gain <= 32'h0;
      ov_ovr <= '0;
      uv_ovr <= '0;
      cal_res <= '0;
    end else begin
      if (scal_wr) begin
        case (paddr[5:0])
          A_CTRL: cfg_update <= pwdata[0];
          A_OV_OVR: ov_ovr <= pwdata[CAL_BITS-1:0];
          A_UV_OVR: uv_ovr <= pwdata[CAL_BITS-1:0];
          A_VCELL_OFS: vcell_ofs <= pwdata;
          A_VDIV_OFS: vdiv_ofs <= pwdata;
          A_CUR_GAIN: cur_gain <= pwdata;
          A_CC_OFS: cc_ofs <= pwdata;
          A_CC_SAMP: cc_samp <= pwdata[7:0];
          default: begin
          end
        endcase
      end
      if (cal_st == CAL_DONE) begin
        cal_res <= cal_code;
        if (cal_uv_sel) begin
          uv_ovr <= cal_code;
        end else begin
          ov_ovr <= cal_code;
        end
      end
    end
  end

  // ==========================================================
  // Threshold trim in use
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cell_overvoltage_threshold <= '0;
      cell_undervoltage_threshold <= '0;
    end else begin
      cell_overvoltage_threshold <= (ov_ovr != '0) ? ov_ovr : fac_ov_trim;
      cell_undervoltage_threshold <= (uv_ovr != '0) ? uv_ovr : fac_uv_trim;
    end
  end

  // ==========================================================
  // Voltage correction
  logic signed [31:0] corr;
  logic signed [32:0] vprod;
  logic [15:0] sel_gain;
  logic signed [31:0] sel_ofs;
  assign corr = meas.counts - fac_offset_trim;
  assign sel_gain = (meas.chan < NCH) ? eff_gain[meas.chan] : 16'h0;
  assign sel_ofs = (meas.chan < NCELL) ? vcell_ofs : ((meas.chan == CH_ADC) ? 32'sh0 : vdiv_ofs);
  assign vprod = $signed({1'b0, sel_gain}) * $signed(corr[15:0]);
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) begin
        volt[i] <= 32'h0;
      end
    end else if (meas.valid && meas.chan < NCH) begin
      volt[meas.chan] <= 32'(vprod >>> 16) - sel_ofs;
    end
  end

  // ==========================================================
  // Temperature offsets
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < NTEMP; i++) begin
        tofs[i] <= 16'h0;
        temp_res[i] <= 16'h0;
      end
    end else begin
      if (wr_en && pg == PG_TOFS && ix < NTEMP) begin
        tofs[ix] <= pwdata[15:0];
      end
      if (temp.valid && temp.chan < NTEMP) begin
        temp_res[temp.chan] <= temp.value + tofs[temp.chan];
      end
    end
  end

  // ==========================================================
  // Offset per sample, restoring division after each offset or sample-count write.
  logic div_start;
  logic div_busy;
  logic div_neg;
  logic [5:0] div_cnt;
  logic [7:0] div_rem;
  logic [31:0] div_quo;
  logic [8:0] div_t;
  logic div_ge;
  logic signed [31:0] ofs_q;
  assign div_t = {div_rem, div_quo[31]};
  assign div_ge = div_t >= {1'b0, cc_samp};
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      div_start <= 1'b0;
      div_busy <= 1'b0;
      div_neg <= 1'b0;
      div_cnt <= 6'h0;
      div_rem <= 8'h0;
      div_quo <= 32'h0;
      ofs_q <= 32'h0;
    end else begin
      div_start <= scal_wr && (paddr[5:0] == A_CC_OFS || paddr[5:0] == A_CC_SAMP);
      if (div_start) begin
        div_neg <= cc_ofs[31];
        div_quo <= cc_ofs[31] ? -cc_ofs : cc_ofs;
        div_rem <= 8'h0;
        div_cnt <= 6'h20;
        div_busy <= 1'b1;
      end else if (div_busy) begin
        div_rem <= div_ge ? 8'(div_t - {1'b0, cc_samp}) : div_t[7:0];
        div_quo <= {div_quo[30:0], div_ge};
        div_cnt <= div_cnt - 6'h1;
        if (div_cnt == 6'h1) begin
          div_busy <= 1'b0;
          ofs_q <= (cc_samp == 8'h0) ? 32'sh0
                 : (div_neg ? -{div_quo[30:0], div_ge} : {div_quo[30:0], div_ge});
        end
      end
    end
  end

  // ==========================================================
  // Current conversion; gains with exponent above 150 are not scaled up.
  logic signed [31:0] raw32;
  logic signed [31:0] cdiff;
  logic signed [56:0] cprod;
  logic [7:0] csh;
  assign raw32 = {{8{cc.raw[23]}}, cc.raw};
  assign cdiff = raw32 - ofs_q;
  assign cprod = cdiff * $signed({1'b0, 1'b1, cur_gain[22:0]});
  assign csh = (cur_gain[30:23] <= 8'd150) ? 8'd150 - cur_gain[30:23] : 8'h0;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cur <= 32'h0;
      raw_cc <= 32'h0;
    end else if (cc.valid) begin
      raw_cc <= raw32;
      if (cur_gain[30:23] == 8'h0) begin
        cur <= 32'h0;
      end else begin
        cur <= cur_gain[31] ? -32'(cprod >>> csh) : 32'(cprod >>> csh);
      end
    end
  end

  mcc_fmul u_cap (
    .a(cur_gain),
    .b(CAP_K),
    .y(cap_next)
  );
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cap_gain <= 32'h0;
    end else begin
      cap_gain <= cap_next;
    end
  end

  // ==========================================================
  // Read multiplexer and bus answer, one wait state per access.
  always_comb begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    case (pg)
      PG_SCALAR: begin
        case (paddr[5:0])
          A_CTRL: rd_data = {31'h0, cfg_update};
          A_CMD: rd_data = {30'h0, div_busy, cal_st != CAL_IDLE};
          A_CALRES: rd_data = 32'(cal_res);
          A_OV_OVR: rd_data = 32'(ov_ovr);
          A_UV_OVR: rd_data = 32'(uv_ovr);
          A_VCELL_OFS: rd_data = vcell_ofs;
          A_VDIV_OFS: rd_data = vdiv_ofs;
          A_CUR_GAIN: rd_data = cur_gain;
          A_CAP_GAIN: rd_data = cap_gain;
          A_CC_OFS: rd_data = cc_ofs;
          A_CC_SAMP: rd_data = {24'h0, cc_samp};
          A_CUR: rd_data = cur;
          A_RAW_CC: rd_data = raw_cc;
          default: rd_err = 1'b1;
        endcase
      end
      PG_GAIN: if (ix < NCH) rd_data = {16'h0, rd_gain[ix]}; else rd_err = 1'b1;
      PG_VOLT: if (ix < NCH) rd_data = volt[ix]; else rd_err = 1'b1;
      PG_TOFS: if (ix < NTEMP) rd_data = 32'(tofs[ix]); else rd_err = 1'b1;
      PG_TEMP: if (ix < NTEMP) rd_data = 32'(temp_res[ix]); else rd_err = 1'b1;
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      if (acc) begin
        prdata <= pwrite ? 32'h0 : rd_data;
        pslverr <= rd_err;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_cell_corr;
    meas.valid && meas.chan == 4'h0 |=> volt[0] + $past(vcell_ofs) ==
      32'(($signed({1'b0, $past(eff_gain[0])}) *
      $signed($past(meas.counts[15:0]) - $past(fac_offset_trim[15:0]))) >>> 16);
  endproperty
  a_cell_corr: assert property (p_cell_corr) else $error("cell correction wrong");

  property p_fallback;
    !gain_wr[1] && fac_gain[1] != 16'h0 |-> eff_gain[1] == fac_gain[1];
  endproperty
  a_fallback: assert property (p_fallback) else $error("factory gain not used");

  property p_written;
    wr_en && pg == PG_GAIN && ix == 4'h1 |=> gain_wr[1] && eff_gain[1] == $past(pwdata[15:0]);
  endproperty
  a_written: assert property (p_written) else $error("written gain not used");

  property p_adc_nom;
    !gain_wr[CH_ADC] && fac_gain[CH_ADC] == 16'h0 |-> eff_gain[CH_ADC] == 16'h0FC8;
  endproperty
  a_adc_nom: assert property (p_adc_nom) else $error("adc nominal gain wrong");

  property p_cfg_zero;
    cfg_update && !gain_wr[2] |-> rd_gain[2] == 16'h0;
  endproperty
  a_cfg_zero: assert property (p_cfg_zero) else $error("unwritten gain not zero");

  property p_refuse;
    scal_wr && paddr[5:0] == A_CMD && !cfg_update && cal_st == CAL_IDLE |=> cal_st == CAL_IDLE;
  endproperty
  a_refuse: assert property (p_refuse) else $error("search started outside update");

  property p_cal_len;
    cal_go |-> ##[1:200] cal_st == CAL_DONE;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("search did not finish");

  property p_cal_store;
    cal_st == CAL_DONE |=> cal_res == $past(cal_code)
      && (($past(cal_uv_sel) ? uv_ovr : ov_ovr) == $past(cal_code));
  endproperty
  a_cal_store: assert property (p_cal_store) else $error("search result not stored");

  property p_override;
    ov_ovr != '0 ##1 $stable(ov_ovr) |-> cell_overvoltage_threshold == ov_ovr;
  endproperty
  a_override: assert property (p_override) else $error("override not applied");

  property p_sext;
    cc.valid |=> raw_cc == {{8{$past(cc.raw[23])}}, $past(cc.raw)};
  endproperty
  a_sext: assert property (p_sext) else $error("raw current not extended");

  property p_temp;
    temp.valid && temp.chan == 4'h0 |=> temp_res[0] == $past(temp.value) + $past(tofs[0]);
  endproperty
  a_temp: assert property (p_temp) else $error("temperature offset wrong");

  c_cal_done: cover property (cal_st == CAL_DONE && cal_uv_sel);
  c_neg_cur: cover property (cc.valid ##1 cur < 0);
  c_cfg_read: cover property (acc && pg == PG_GAIN && cfg_update);
endmodule // mcc_top
`default_nettype wire

/* File: tb/mcc_line_tester.sv */
// Production-line tester model: holds a voltage across the top cell inputs.
// Assumes the comparator threshold rises with the trial coefficient.
`timescale 1ns/1ps
`default_nettype none
module mcc_line_tester (
  input wire logic [mcc_pkg::CAL_BITS-1:0] cal_code,
  input wire logic [mcc_pkg::CAL_BITS-1:0] applied,
  output logic comp_trip
);
  import mcc_pkg::*;
  assign comp_trip = (applied >= cal_code);
endmodule // mcc_line_tester
`default_nettype wire

/* File: tb/test_mcc_top.sv */
// Self-checking bench for the calibration correction block.
// Assumes the APB timing and register map of the design hand-over.
`timescale 1ns/1ps
`default_nettype none
module test_mcc_top;
  import mcc_pkg::*;
  logic mclk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic full_access_state = 1'h1;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic serr;
  logic comp_trip;
  mcc_meas_t meas = '0;
  mcc_temp_t temp = '0;
  mcc_cc_t cc = '0;
  logic [NCH-1:0][15:0] fac_gain = '0;
  logic [CAL_BITS-1:0] applied = 8'h0;
  logic [CAL_BITS-1:0] cal_code;
  logic [CAL_BITS-1:0] ovt;
  logic [CAL_BITS-1:0] uvt;
  logic uvs;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;

  always #25 mclk = ~mclk;

  mcc_top u_dut (
    .mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .full_access_state(full_access_state), .meas(meas),
    .fac_offset_trim(32'h100), .fac_gain(fac_gain), .temp(temp), .cc(cc),
    .fac_ov_trim(8'h33), .fac_uv_trim(8'h3C), .comp_trip(comp_trip),
    .cal_code(cal_code), .cal_uv_sel(uvs), .cell_overvoltage_threshold(ovt),
    .cell_undervoltage_threshold(uvt)
  );

  mcc_line_tester u_tester (.cal_code(cal_code), .applied(applied), .comp_trip(comp_trip));

  // ==========================================================
  // Bus and check tasks
  task final_report;
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] sa(input logic [5:0] a);
    return {6'h0, a};
  endfunction

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) errors++;
    rd = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Polls one command status bit until it clears.
  task wait_clear(input int b);
    int k;
    k = 0;
    do begin
      apb(1'h0, sa(A_CMD), 32'h0);
      k++;
    end while (rd[b] !== 1'h0 && k < 100);
    if (rd[b] !== 1'h0) errors++;
  endtask

  task mchk(input logic [3:0] ch, input logic [31:0] cnt, input logic [15:0] exp);
    @(posedge mclk);
    meas <= '{1'h1, ch, cnt};
    @(posedge mclk);
    meas.valid <= 1'h0;
    apb(1'h0, {PG_VOLT, ch, 2'h0}, 32'h0);
    chk(rd[15:0], exp);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report;
    end
  end

  // ==========================================================
  // Test sequence
  initial begin
    fac_gain[10] = 16'h1000;
    repeat (4) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
    rchk(sa(A_CTRL), 32'h0);
    rchk(sa(A_CC_SAMP), 32'h1);
    chk(ovt, 32'h33);
    chk(uvt, 32'h3C);
    apb(1'h0, 12'hFFC, 32'h0);
    chk(serr, 32'h1);
    chk(rd, 32'h0);
    apb(1'h1, sa(A_CMD), 32'(CMD_OV));
    rchk(sa(A_CMD), 32'h0);
    rchk(12'h040, 32'h2F58);
    full_access_state <= 1'h0;
    rchk(12'h040, 32'h0);
    full_access_state <= 1'h1;
    apb(1'h1, sa(A_CTRL), 32'h1);
    rchk(12'h040, 32'h0);
    apb(1'h1, 12'h044, 32'h6000);
    rchk(12'h044, 32'h6000);
    apb(1'h1, sa(A_VCELL_OFS), 32'hA);
    apb(1'h1, sa(A_VDIV_OFS), 32'h5);
    apb(1'h1, sa(A_CTRL), 32'h0);
    rchk(12'h040, 32'h2F58);
    rchk(12'h044, 32'h6000);
    mchk(4'h0, 32'h4100, 16'hBCC);
    mchk(4'h1, 32'h2100, 16'hBF6);
    mchk(4'h2, 32'h00F0, 16'hFFF3);
    mchk(4'hA, 32'h1100, 16'h00FB);
    mchk(4'hB, 32'h4100, 16'hBD1);
    mchk(4'hD, 32'h4100, 16'h3F2);
    // unit gain, as for a 7.4768 milliohm sense resistor.
    apb(1'h1, sa(A_CUR_GAIN), 32'h3F800000);
    apb(1'h1, sa(A_CC_OFS), 32'h8);
    apb(1'h1, sa(A_CC_SAMP), 32'h2);
    wait_clear(1);
    rchk(sa(A_CAP_GAIN), CAP_K);
    @(posedge mclk);
    cc <= '{1'h1, 24'hFFFFF0};
    @(posedge mclk);
    cc.valid <= 1'h0;
    rchk(sa(A_RAW_CC), 32'hFFFFFFF0);
    rchk(sa(A_CUR), 32'hFFFFFFEC);
    for (int n = 0; n < NTEMP; n++) begin
      apb(1'h1, {PG_TOFS, 4'(n), 2'h0}, 32'(-n));
      @(posedge mclk);
      temp <= '{1'h1, 4'(n), 16'hBB8};
      @(posedge mclk);
      temp.valid <= 1'h0;
      apb(1'h0, {PG_TEMP, 4'(n), 2'h0}, 32'h0);
      chk(rd[15:0], 16'hBB8 - 16'(n));
    end
    // update mode entered once, before both searches.
    apb(1'h1, sa(A_CTRL), 32'h1);
    applied <= 8'h5A;
    apb(1'h1, sa(A_CMD), 32'(CMD_OV));
    wait_clear(0);
    rchk(sa(A_CALRES), 32'h5A);
    rchk(sa(A_OV_OVR), 32'h5A);
    chk(ovt, 32'h5A);
    chk(uvs, 32'h0);
    applied <= 8'hA5;
    apb(1'h1, sa(A_CMD), 32'(CMD_UV));
    wait_clear(0);
    rchk(sa(A_CALRES), 32'hA5);
    rchk(sa(A_UV_OVR), 32'hA5);
    chk(uvt, 32'hA5);
    chk(uvs, 32'h1);
    final_report;
  end
endmodule // test_mcc_top
`default_nettype wire
